//--- logic/gps_parallel_port.sv
// Three-pin port and eight-bit data port with host slave port
//
// Behaviour
// RULE1: three pins, each input or output
// RULE2: direction 1 tristates, 0 drives latch
// RULE3: latch register reads latch, not pins
// RULE4: analog-selected pin reads zero
// RULE5: software keeps analog pins as inputs
// RULE6: after reset all three pins analog
// RULE7: bit 7 input-full while word waits
// RULE8: bit 6 output-full until host reads
// RULE9: bit 5 overflow, cleared only by software
// RULE10: bit 4 selects slave port mode
// RULE11: bit 3 zero, bits 2-0 direction
// RULE12: pins are read, write, chip select
// RULE13: low read with select returns data
// RULE14: low write with select loads data
// RULE15: strobes ignored while select high
// RULE16: data port reachable by host strobes
// RULE17: host sees plain byte latch
// RULE18: write starts at first select+write low
// RULE19: read starts at first select+read low
// RULE20: software sets inputs and digital config
// RULE21: data direction 1 input, 0 drives
// RULE22: host write sets input-full and flag
// RULE23: CPU write sets output-full, read clears
//
// Local design decisions: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
module gps_parallel_port
    import gps_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              clk_sys_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    // AHB-Lite slave
    input  wire logic              hsel_i,
    input  wire logic [31:0]       haddr_i,
    input  wire logic [1:0]        htrans_i,
    input  wire logic              hwrite_i,
    input  wire logic [2:0]        hsize_i,
    input  wire logic              hready_i,
    input  wire logic [31:0]       hwdata_i,
    output logic [31:0]            hrdata_o,
    output logic                   hreadyout_o,
    output logic                   hresp_o,
    // Control pins
    input  wire logic [CTL_W-1:0]  ctl_pin_i,
    output logic [CTL_W-1:0]       ctl_pin_o,
    output logic [CTL_W-1:0]       ctl_pin_oe_o,
    // Data port pins
    input  wire logic [DP_W-1:0]   dp_pin_i,
    output logic [DP_W-1:0]        dp_pin_o,
    output logic [DP_W-1:0]        dp_pin_oe_o,
    // Status
    output logic                   slave_port_interrupt_flag_o
);

    typedef struct packed {
        logic              hready;
        logic [31:0]       hrdata;
        logic              pend;
        logic              pend_wr;
        logic              pend_ok;
        logic [7:0]        pend_addr;
        logic [CTL_W-1:0]  ctl_latch;
        logic [CTL_W-1:0]  ctl_dir;
        logic              mode;
        logic              input_full_flag;
        logic              output_full_flag;
        logic              input_overflow_flag;
        logic [DP_W-1:0]   dp_latch;
        logic [DP_W-1:0]   dp_dir;
        logic [DP_W-1:0]   in_buf;
        logic [CTL_W-1:0]  anl_cfg;
        logic              irq;
        logic [CTL_W-1:0]  ctl_out;
        logic [CTL_W-1:0]  ctl_oe;
        logic [DP_W-1:0]   dp_out;
        logic [DP_W-1:0]   dp_oe;
    } gps_state_s;

    gps_state_s       st;
    gps_state_s       next_st;
    logic             accept;
    logic             rd_active;
    logic             rd_done;
    logic             wr_active;
    logic             wr_start;
    logic             wr_done;
    logic [CTL_W-1:0] ctl_digital;
    logic [31:0]      rd_value;
    logic             cpu_rd_dp;
    logic             cpu_wr_dp;

    gps_strobe_det u_det (
        .clk_sys_i   (clk_sys_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .enable_i    (st.mode),
        .cs_n_i      (ctl_pin_i[PIN_CS]), // see RULE12
        .rd_n_i      (ctl_pin_i[PIN_RD]),
        .wr_n_i      (ctl_pin_i[PIN_WR]),
        .rd_active_o (rd_active),
        .rd_done_o   (rd_done),
        .wr_active_o (wr_active),
        .wr_start_o  (wr_start),
        .wr_done_o   (wr_done)
    );

    // Address phase taken only when the bus is ready
    assign accept = hsel_i & htrans_i[HTRANS_ACT] & hready_i & st.hready;

    // Analog-selected pins are masked
    assign ctl_digital = ctl_pin_i & st.anl_cfg;  // see RULE4

    assign cpu_rd_dp = st.pend & st.pend_ok & ~st.pend_wr
                       & (st.pend_addr == OFS_DP_PINS);
    assign cpu_wr_dp = st.pend & st.pend_ok & st.pend_wr
                       & (st.pend_addr == OFS_DP_PINS);

    always_comb begin
        rd_value = 32'h0000_0000;
        if (st.pend_ok) begin
            unique case (st.pend_addr)
                OFS_CTL_PORT:  rd_value[CTL_W-1:0] = ctl_digital;
                OFS_CTL_LATCH: rd_value[CTL_W-1:0] = st.ctl_latch; // see RULE3
                OFS_CTL_DIRST: begin
                    rd_value[BIT_IBF]   = st.input_full_flag;  // see RULE7
                    rd_value[BIT_OBF]   = st.output_full_flag;  // see RULE8
                    rd_value[BIT_INPUT_OVERFLOW_FLAG]  = st.input_overflow_flag; // see RULE9
                    rd_value[BIT_MODE]  = st.mode; // see RULE10
                    rd_value[CTL_W-1:0] = st.ctl_dir; // see RULE11
                end
                OFS_DP_PINS:   rd_value[DP_W-1:0] =
                                   st.mode ? st.in_buf : dp_pin_i;
                OFS_DP_LATCH:  rd_value[DP_W-1:0] = st.dp_latch;
                OFS_DP_DIR:    rd_value[DP_W-1:0] = st.dp_dir;
                OFS_ANL_CFG:   rd_value[CTL_W-1:0] = st.anl_cfg;
                OFS_IRQ_FLAG:  rd_value[BIT_IRQ] = st.irq;
                default:       rd_value = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        next_st = st;

        // Bus slave: one wait cycle, then the data phase completes
        if (accept) begin
            next_st.pend      = 1'b1;
            next_st.pend_wr   = hwrite_i;
            next_st.pend_addr = haddr_i[7:0];
            next_st.pend_ok   = (haddr_i[31:8] == 24'h000000)
                                & (haddr_i[1:0] == 2'b00);
            next_st.hready    = 1'b0;
        end else if (st.pend) begin
            next_st.pend   = 1'b0;
            next_st.hready = 1'b1;
            if (!st.pend_wr) begin
                next_st.hrdata = rd_value;
            end
        end

        // Software writes
        if (st.pend & st.pend_wr & st.pend_ok) begin
            unique case (st.pend_addr)
                OFS_CTL_PORT, OFS_CTL_LATCH: begin
                    next_st.ctl_latch = hwdata_i[CTL_W-1:0];
                end
                OFS_CTL_DIRST: begin
                    next_st.mode    = hwdata_i[BIT_MODE];
                    next_st.ctl_dir = hwdata_i[CTL_W-1:0];
                    if (!hwdata_i[BIT_INPUT_OVERFLOW_FLAG]) begin
                        next_st.input_overflow_flag = 1'b0; // see RULE9
                    end
                end
                OFS_DP_PINS, OFS_DP_LATCH: begin
                    next_st.dp_latch = hwdata_i[DP_W-1:0];
                end
                OFS_DP_DIR:   next_st.dp_dir  = hwdata_i[DP_W-1:0];
                OFS_ANL_CFG:  next_st.anl_cfg = hwdata_i[CTL_W-1:0];
                OFS_IRQ_FLAG: begin
                    if (hwdata_i[BIT_IRQ]) begin
                        next_st.irq = 1'b0;
                    end
                end
                default: next_st.irq = st.irq;
            endcase
        end

        // CPU reading the data port in slave mode empties the input
        if (cpu_rd_dp & st.mode) begin
            next_st.input_full_flag = 1'b0; // see RULE22
        end

        // Host read completes: output buffer drained
        if (rd_done) begin
            next_st.output_full_flag = 1'b0; // see RULE23
            next_st.irq = 1'b1;
        end

        // CPU writing the data port in slave mode fills the output
        if (cpu_wr_dp & st.mode) begin
            next_st.output_full_flag = 1'b1; // see RULE23
        end

        // Host write: sample the bus while the strobe is low and input-full is clear
        if (wr_active & ~st.input_full_flag) begin
            next_st.in_buf = dp_pin_i; // see RULE14
        end
        if (wr_start & st.input_full_flag) begin
            next_st.input_overflow_flag = 1'b1; // see RULE9
        end
        if (wr_done) begin
            next_st.input_full_flag = 1'b1; // see RULE22
            next_st.irq = 1'b1;
        end

        // Pin drivers
        next_st.ctl_out = next_st.ctl_latch;
        next_st.ctl_oe  = ~next_st.ctl_dir; // see RULE2
        next_st.dp_out  = next_st.dp_latch;
        if (st.mode) begin
            next_st.dp_oe = {DP_W{rd_active}}; // see RULE13
        end else begin
            next_st.dp_oe = ~next_st.dp_dir; // see RULE21
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st           <= '0;
            st.hready    <= 1'b1;
            st.hrdata    <= RST_HRDATA;
            st.ctl_latch <= RST_CTL_LAT;
            st.ctl_dir   <= RST_CTL_DIR;
            st.dp_latch  <= RST_DP_LAT;
            st.dp_dir    <= RST_DP_DIR;
            st.anl_cfg   <= RST_ANL_CFG; // see RULE6
            st.ctl_out   <= RST_CTL_LAT;
            st.ctl_oe    <= ~RST_CTL_DIR;
            st.dp_out    <= RST_DP_LAT;
            st.dp_oe     <= ~RST_DP_DIR;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign hrdata_o                    = st.hrdata;
    assign hreadyout_o                 = st.hready;
    assign hresp_o                     = 1'b0;
    assign ctl_pin_o                   = st.ctl_out; // see RULE1
    assign ctl_pin_oe_o                = st.ctl_oe;
    assign dp_pin_o                    = st.dp_out; // see RULE17
    assign dp_pin_oe_o                 = st.dp_oe;
    assign slave_port_interrupt_flag_o = st.irq;

    property p_dir_drive;
        @(posedge clk_sys_i) disable iff (rst_i)
        ce_i |=> (ctl_pin_oe_o == ~st.ctl_dir);
    endproperty
    a_dir_drive: assert property (p_dir_drive) // see RULE2
        else $error("control pin enable does not follow direction");

    property p_wr_sets_ibf;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && wr_done) |=> st.input_full_flag && st.irq;
    endproperty
    a_wr_sets_ibf: assert property (p_wr_sets_ibf) // see RULE22
        else $error("host write did not set input full");

    property p_ovf;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && wr_start && st.input_full_flag) |=> st.input_overflow_flag;
    endproperty
    a_ovf: assert property (p_ovf) // see RULE9
        else $error("overflow not flagged");

    property p_ovf_hold;
        @(posedge clk_sys_i) disable iff (rst_i)
        (st.input_overflow_flag && !(st.pend && st.pend_wr)) |=> st.input_overflow_flag;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) // see RULE9
        else $error("overflow cleared without a write");

    property p_rd_clears_obf;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_done && !cpu_wr_dp) |=> !st.output_full_flag;
    endproperty
    a_rd_clears_obf: assert property (p_rd_clears_obf) // see RULE23
        else $error("host read did not clear output full");

    property p_cs_ignore;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && st.mode && ctl_pin_i[PIN_CS]) |=>
            dp_pin_oe_o == {DP_W{1'b0}} && $stable(st.in_buf);
    endproperty
    a_cs_ignore: assert property (p_cs_ignore) // see RULE15
        else $error("strobe taken while deselected");

    property p_host_read_drive;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && st.mode && rd_active) ##1 ce_i |->
            dp_pin_oe_o == {DP_W{1'b1}};
    endproperty
    a_host_read_drive: assert property (p_host_read_drive) // see RULE19
        else $error("data port not driven during host read");

    property p_analog_zero;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && st.pend && !st.pend_wr && st.pend_ok
            && st.pend_addr == OFS_CTL_PORT) |=>
            (hrdata_o[CTL_W-1:0] & ~$past(st.anl_cfg)) == 3'h0;
    endproperty
    a_analog_zero: assert property (p_analog_zero) // see RULE4
        else $error("analog pin did not read zero");

    property p_bus_wait;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && accept) |=> !hreadyout_o ##1 (hreadyout_o || !ce_i);
    endproperty
    a_bus_wait: assert property (p_bus_wait) // one AHB-Lite wait cycle, a local design decision
        else $error("bus answer not after one wait cycle");

endmodule // gps_parallel_port

//--- logic/gps_pkg.sv
// Constants for the general purpose port with host slave port
package gps_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTL_PORT   = 8'h00;
    localparam logic [7:0] OFS_CTL_LATCH  = 8'h04;
    localparam logic [7:0] OFS_CTL_DIRST  = 8'h08;
    localparam logic [7:0] OFS_DP_PINS    = 8'h0C;
    localparam logic [7:0] OFS_DP_LATCH   = 8'h10;
    localparam logic [7:0] OFS_DP_DIR     = 8'h14;
    localparam logic [7:0] OFS_ANL_CFG    = 8'h18;
    localparam logic [7:0] OFS_IRQ_FLAG   = 8'h1C;

    // Field positions of the direction and status register, and of the interrupt flag register (BIT_IRQ)
    localparam int BIT_IBF     = 7;
    localparam int BIT_OBF     = 6;
    localparam int BIT_INPUT_OVERFLOW_FLAG    = 5;
    localparam int BIT_MODE    = 4;
    localparam int BIT_IRQ     = 0;

    // Widths
    localparam int CTL_W = 3;
    localparam int DP_W  = 8;

    // Reset values
    localparam logic [2:0]  RST_CTL_DIR  = 3'h7;
    localparam logic [2:0]  RST_CTL_LAT  = 3'h0;
    localparam logic [7:0]  RST_DP_DIR   = 8'hFF;
    localparam logic [7:0]  RST_DP_LAT   = 8'h00;
    localparam logic [2:0]  RST_ANL_CFG  = 3'h0;
    localparam logic [31:0] RST_HRDATA   = 32'h0000_0000;

    // Strobe pin positions on the control pin port
    localparam int PIN_RD = 0;
    localparam int PIN_WR = 1;
    localparam int PIN_CS = 2;

    // AHB transfer type bit that marks an active transfer
    localparam int HTRANS_ACT = 1;

endpackage

//--- logic/gps_strobe_det.sv
// Start and end detection of host read and write strobes
`timescale 1ns/1ps
module gps_strobe_det
    import gps_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Strobe levels
    input  wire logic enable_i,
    input  wire logic cs_n_i,
    input  wire logic rd_n_i,
    input  wire logic wr_n_i,
    // Events
    output logic      rd_active_o,
    output logic      rd_done_o,
    output logic      wr_active_o,
    output logic      wr_start_o,
    output logic      wr_done_o
);

    typedef struct packed {
        logic rd_prev;
        logic wr_prev;
    } gps_det_s;

    gps_det_s st;
    gps_det_s next_st;
    logic     rd_now;
    logic     wr_now;

    // Strobes count only while selected
    assign rd_now = enable_i & ~cs_n_i & ~rd_n_i; // see RULE15
    assign wr_now = enable_i & ~cs_n_i & ~wr_n_i; // see RULE15

    always_comb begin
        next_st         = st;
        next_st.rd_prev = rd_now;
        next_st.wr_prev = wr_now;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign rd_active_o = rd_now; // see RULE19
    assign rd_done_o   = st.rd_prev & ~rd_now;
    assign wr_active_o = wr_now;
    assign wr_start_o  = wr_now & ~st.wr_prev; // see RULE18
    assign wr_done_o   = st.wr_prev & ~wr_now;

endmodule // gps_strobe_det

//--- verif/gps_host_model.sv
// Behavioural external host driving the slave port strobes and bus
`timescale 1ns/1ps
module gps_host_model (
    // Clock and resolved data bus
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] bus_i,
    // Strobes {cs, wr, rd}, all active low, and host data
    output logic [2:0]      ctl_o,
    output logic [7:0]      data_o
);
    initial begin
        ctl_o  = 3'h7;
        data_o = 8'h00;
    end

    // One write strobe; cs_n high is a cycle for another device
    task automatic write_byte(input logic [7:0] b, input logic cs_n);
        @(posedge clk_sys_i);
        data_o <= b;
        ctl_o  <= {cs_n, 1'b0, 1'b1};
        repeat (3) @(posedge clk_sys_i);
        ctl_o  <= 3'h7;
        @(posedge clk_sys_i);
        data_o <= ~b; // Bus shows the inverted byte one cycle after release
        repeat (2) @(posedge clk_sys_i);
    endtask

    // One read strobe; byte taken at the edge before release
    task automatic read_byte(output logic [7:0] b);
        @(posedge clk_sys_i);
        data_o <= ~data_o;
        ctl_o  <= 3'h2;
        repeat (3) @(posedge clk_sys_i);
        b = bus_i;
        ctl_o  <= 3'h7;
        repeat (3) @(posedge clk_sys_i);
    endtask
endmodule // gps_host_model

//--- verif/testbench.sv
// Self-checking bench for the port with host slave port
`timescale 1ns/1ps
module testbench;
    import gps_pkg::*;
    logic        clk_sys_i;
    logic        rst_i;
    logic        ce_i;
    logic        hsel_i;
    logic [31:0] haddr_i;
    logic [1:0]  htrans_i;
    logic        hwrite_i;
    logic [31:0] hwdata_i;
    logic [31:0] hrdata_o;
    logic        hreadyout_o;
    logic        hresp_o;
    logic [2:0]  ctl_pin_o;
    logic [2:0]  ctl_pin_oe_o;
    logic [2:0]  host_ctl;
    logic [2:0]  ctl_bus;
    logic [7:0]  dp_pin_o;
    logic [7:0]  dp_pin_oe_o;
    logic [7:0]  host_d;
    logic [7:0]  dp_bus;
    logic        flag_o;
    int          n_errors;
    int          cmp_count;

    assign ctl_bus = (ctl_pin_oe_o & ctl_pin_o) | (~ctl_pin_oe_o & host_ctl);
    assign dp_bus  = (dp_pin_oe_o & dp_pin_o) | (~dp_pin_oe_o & host_d);

    gps_parallel_port gps_parallel_port_inst (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(3'h2), .hready_i(hreadyout_o),
        .hwdata_i(hwdata_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .ctl_pin_i(ctl_bus), .ctl_pin_o(ctl_pin_o),
        .ctl_pin_oe_o(ctl_pin_oe_o), .dp_pin_i(dp_bus),
        .dp_pin_o(dp_pin_o), .dp_pin_oe_o(dp_pin_oe_o),
        .slave_port_interrupt_flag_o(flag_o)
    );

    gps_host_model gps_host_model_inst (
        .clk_sys_i(clk_sys_i), .bus_i(dp_bus),
        .ctl_o(host_ctl), .data_o(host_d)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Single word transfer; waits on hready with a bound
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd);
        int i;
        @(posedge clk_sys_i);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i  <= {24'h0, a};
        hwrite_i <= w;
        i = 0;
        do begin
            @(posedge clk_sys_i);
            i++;
        end while (hreadyout_o !== 1'b1 && i < 50);
        htrans_i <= 2'h0;
        hwdata_i <= wd;
        do begin
            @(posedge clk_sys_i);
            i++;
        end while (hreadyout_o !== 1'b1 && i < 100);
        rd = hrdata_o;
        if (i >= 100) begin
            n_errors++;
            end_sim();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(a, 1'b1, d, x);
    endtask

    task automatic chk_rd(input string nm, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] x;
        xfer(a, 1'b0, 32'h0, x);
        check(nm, x, exp);
    endtask

    task automatic t_reset();
        check("ctl oe", {29'h0, ctl_pin_oe_o}, 32'h0);
        check("hresp", {31'h0, hresp_o}, 32'h0);
        chk_rd("dirst", OFS_CTL_DIRST, 32'h07);
        chk_rd("dp dir", OFS_DP_DIR, 32'hFF);
        chk_rd("ctl port", OFS_CTL_PORT, 32'h0);
        chk_rd("unmapped", 8'h40, 32'h0);
        $display("t_reset done");
    endtask

    task automatic t_gpio();
        wr(OFS_ANL_CFG, 32'h7);
        wr(OFS_CTL_LATCH, 32'h5);
        wr(OFS_CTL_DIRST, 32'h0A);
        chk_rd("dirst", OFS_CTL_DIRST, 32'h02);
        check("ctl oe", {29'h0, ctl_pin_oe_o}, 32'h5);
        check("ctl o", {29'h0, ctl_pin_o}, 32'h5);
        chk_rd("ctl latch", OFS_CTL_LATCH, 32'h5);
        chk_rd("ctl port", OFS_CTL_PORT, 32'h7);
        wr(OFS_ANL_CFG, 32'h6);
        chk_rd("ctl analog", OFS_CTL_PORT, 32'h6);
        wr(OFS_DP_LATCH, 32'hA5);
        wr(OFS_DP_DIR, 32'h0F);
        chk_rd("dp latch", OFS_DP_LATCH, 32'hA5);
        check("dp oe", {24'h0, dp_pin_oe_o}, 32'hF0);
        check("dp o", {24'h0, dp_pin_o}, 32'hA5);
        wr(OFS_ANL_CFG, 32'h7);
        $display("t_gpio done");
    endtask

    task automatic t_host_write();
        wr(OFS_CTL_DIRST, 32'h17);
        gps_host_model_inst.write_byte(8'h3C, 1'b0);
        chk_rd("ibf set", OFS_CTL_DIRST, 32'h97);
        check("flag", {31'h0, flag_o}, 32'h1);
        chk_rd("host byte", OFS_DP_PINS, 32'h3C);
        chk_rd("ibf clr", OFS_CTL_DIRST, 32'h17);
        $display("t_host_write done");
    endtask

    task automatic t_overflow();
        gps_host_model_inst.write_byte(8'h11, 1'b0);
        gps_host_model_inst.write_byte(8'h22, 1'b0);
        chk_rd("ovf set", OFS_CTL_DIRST, 32'hB7);
        chk_rd("first kept", OFS_DP_PINS, 32'h11);
        chk_rd("ovf sticky", OFS_CTL_DIRST, 32'h37);
        wr(OFS_CTL_DIRST, 32'h17);
        chk_rd("ovf clr", OFS_CTL_DIRST, 32'h17);
        $display("t_overflow done");
    endtask

    task automatic t_host_read();
        logic [7:0] b;
        wr(OFS_IRQ_FLAG, 32'h1);
        check("flag clr", {31'h0, flag_o}, 32'h0);
        wr(OFS_DP_PINS, 32'h5A);
        chk_rd("obf set", OFS_CTL_DIRST, 32'h57);
        gps_host_model_inst.read_byte(b);
        check("host read", {24'h0, b}, 32'h5A);
        chk_rd("obf clr", OFS_CTL_DIRST, 32'h17);
        check("flag", {31'h0, flag_o}, 32'h1);
        $display("t_host_read done");
    endtask

    task automatic t_deselect();
        wr(OFS_IRQ_FLAG, 32'h1);
        gps_host_model_inst.write_byte(8'h99, 1'b1);
        chk_rd("no write", OFS_CTL_DIRST, 32'h17);
        check("no flag", {31'h0, flag_o}, 32'h0);
        $display("t_deselect done");
    endtask

    // Host write while the clock enable is low must leave no trace
    task automatic t_freeze();
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        gps_host_model_inst.write_byte(8'h44, 1'b0);
        check("frozen flag", {31'h0, flag_o}, 32'h0);
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        chk_rd("frozen ibf", OFS_CTL_DIRST, 32'h17);
        $display("t_freeze done");
    endtask

    initial begin
        n_errors  = 0;
        cmp_count = 0;
        rst_i     = 1'b1;
        ce_i      = 1'b1;
        hsel_i    = 1'b0;
        haddr_i   = 32'h0;
        htrans_i  = 2'h0;
        hwrite_i  = 1'b0;
        hwdata_i  = 32'h0;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        t_reset();
        t_gpio();
        t_host_write();
        t_overflow();
        t_host_read();
        t_deselect();
        t_freeze();
        end_sim();
    end
endmodule // testbench
